// >>> fbmcu_core.sv
// core datapath: alu, working and flag registers, ram pointers, sequencing
//
// Chosen here: register access over AXI4-Lite and the register offsets.
`timescale 1ns/10ps
module fbmcu_core
  import fbmcu_pkg::*;
#(
  parameter int          PAGE_BITS = 3,      // 2 on the small variant
  parameter int          NEST      = 4,      // return levels
  parameter logic [10:0] IRQ_VEC   = 11'h001 // service entry, arbitrary
) (
  input  wire logic                   mclk,
  input  wire logic                   resetn,
  input  wire logic [7:0]             awaddr,
  input  wire logic                   awvalid,
  output logic                        awready,
  input  wire logic [31:0]            wdata,
  input  wire logic [3:0]             wstrb,
  input  wire logic                   wvalid,
  output logic                        wready,
  output logic [1:0]                  bresp,
  output logic                        bvalid,
  input  wire logic                   bready,
  input  wire logic [7:0]             araddr,
  input  wire logic                   arvalid,
  output logic                        arready,
  output logic [31:0]                 rdata,
  output logic [1:0]                  rresp,
  output logic                        rvalid,
  input  wire logic                   rready,
  input  wire logic                   init_pin_n,
  input  wire logic                   irq_pin_n,
  input  wire logic                   irq_block_emu,
  input  wire logic [7:0]             ext_rom_word,
  output logic [10:0]                 ext_rom_addr,
  output logic [PAGE_BITS+3:0]        ram_addr,
  output logic                        core_clock_out
);
  default clocking @(posedge mclk); endclocking
  default disable iff (!resetn);

  //********************************************************************
  // helpers
  //********************************************************************
  // word decode, low address bits ignored
  function automatic logic hit(input logic [7:0] a, input logic [7:0] o);
    hit = (a[7:2] == o[7:2]);
  endfunction

  // byte strobes widened to a bit mask
  function automatic logic [31:0] lanes(input logic [3:0] s);
    lanes = {{8{s[3]}}, {8{s[2]}}, {8{s[1]}}, {8{s[0]}}};
  endfunction

  //********************************************************************
  // declarations
  //********************************************************************
  logic [3:0]           work_reg;     // accumulator
  fbmcu_flag_t          flag_reg;     // g, enable, branch, carry
  logic [3:0]           ram_low_ptr;  // in-page address
  logic [PAGE_BITS-1:0] ram_page_ptr; // page select
  fbmcu_cmd_t           cmd_q;        // instruction under way
  fbmcu_state_t         state;        // sequencer
  logic [MCYC_W-1:0]    exec_cnt;     // clocks left in machine cycle
  logic [MCYC_W-1:0]    mcyc_cnt;     // free machine cycle timer
  logic [2:0]           depth;        // levels in use
  logic [10:0]          stack [NEST]; // return addresses
  logic [1:0]           pin_n;        // raw request pins
  logic [2:0]           low_cnt [2];  // low run length
  logic                 qual [2];     // qualified low level
  logic                 irq_qual_d;   // edge memory
  logic                 irq_pend;     // accepted request waiting
  logic [9:0]           run_len;      // clocks since launch
  logic                 aw_got;
  logic                 w_got;
  logic [7:0]           aw_q;
  logic [31:0]          wd_q;
  logic [31:0]          rd_val;
  logic                 rd_ok;
  logic                 wr_go;
  logic                 wr_ok;
  logic                 init_act;
  logic                 tick;
  logic                 launch;
  logic                 exec_done;
  logic                 irq_take;
  logic                 push;
  logic [1:0]           push_idx;
  logic [1:0]           pop_idx;
  logic [10:0]          pc_inc;
  logic [3:0]           alu_operand_a;
  logic [3:0]           alu_operand_b;
  logic [4:0]           alu_sum;
  logic                 is_arith;

  //********************************************************************
  // request pin qualification
  //********************************************************************
  assign pin_n = {irq_pin_n, init_pin_n}; // single interrupt input RULE_18

  // a low must outlast four clocks; glitches shorter than that vanish
  for (genvar i = 0; i < 2; i++) begin : g_filt
    always_ff @(posedge mclk or negedge resetn) begin
      if (!resetn) begin
        low_cnt[i] <= 3'h0;
        qual[i]    <= 1'b0;
      end else if (pin_n[i]) begin
        low_cnt[i] <= 3'h0;
        qual[i]    <= 1'b0;
      end else if (low_cnt[i] != FILT_CNT) begin
        low_cnt[i] <= low_cnt[i] + 3'h1;
      end else begin
        qual[i]    <= 1'b1; // RULE_01 RULE_02
      end
    end
  end

  assign init_act = qual[0];

  // rearm needs a high sample; the source keeps it high long enough
  always_ff @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      irq_qual_d <= 1'b0;
    end else begin
      irq_qual_d <= qual[1]; // RULE_03
    end
  end

  // pending request: a new request wins over the take
  always_ff @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      irq_pend <= 1'b0;
    end else if (init_act) begin
      irq_pend <= 1'b0;
    end else if (qual[1] && !irq_qual_d) begin
      irq_pend <= 1'b1; // RULE_02
    end else if (irq_take) begin
      irq_pend <= 1'b0;
    end
  end

  //********************************************************************
  // machine cycle timer
  //********************************************************************
  // restarted by initialize so requests align to its boundaries
  always_ff @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      mcyc_cnt <= '0;
    end else if (init_act || mcyc_cnt == MCYC_LAST) begin
      mcyc_cnt <= '0; // RULE_24
    end else begin
      mcyc_cnt <= mcyc_cnt + MCYC_W'(1);
    end
  end

  assign tick = (mcyc_cnt == MCYC_LAST);

  // internal clock out, high in the first half of each cycle
  always_ff @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      core_clock_out <= 1'b0;
    end else begin
      core_clock_out <= (mcyc_cnt < MCYC_HALF);
    end
  end

  //********************************************************************
  // interrupt entry
  //********************************************************************
  // taken only between instructions on a cycle boundary
  assign irq_take = tick && irq_pend && flag_reg.irq_allow // RULE_10 RULE_24
                    && !irq_block_emu && state == ST_IDLE // RULE_20
                    && depth < 3'(NEST) && !init_act; // RULE_17

  //********************************************************************
  // instruction sequencer
  //********************************************************************
  assign launch = wr_go && hit(aw_q, A_CMD) && state == ST_IDLE
                  && !init_act && !irq_take;
  assign exec_done = !init_act && state != ST_IDLE && exec_cnt == '0
                     && (state == ST_RUN2 || !cmd_q.two);

  // commands arriving while busy are dropped
  always_ff @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      state    <= ST_IDLE;
      exec_cnt <= '0;
      cmd_q    <= '0;
    end else if (init_act) begin
      state    <= ST_IDLE;
    end else if (launch) begin
      state    <= ST_RUN1;
      exec_cnt <= MCYC_LAST;
      cmd_q    <= wd_q;
    end else begin
      unique case (state)
        ST_IDLE: begin
          exec_cnt <= '0;
        end
        ST_RUN1: begin
          if (exec_cnt != '0) begin
            exec_cnt <= exec_cnt - MCYC_W'(1);
          end else if (cmd_q.two) begin
            state    <= ST_RUN2; // RULE_19
            exec_cnt <= MCYC_LAST;
          end else begin
            state    <= ST_IDLE; // RULE_19
          end
        end
        ST_RUN2: begin
          if (exec_cnt != '0) begin
            exec_cnt <= exec_cnt - MCYC_W'(1);
          end else begin
            state    <= ST_IDLE;
          end
        end
        default: begin
          state    <= ST_IDLE; // unused code
        end
      endcase
    end
  end

  // launch-to-finish length, read only by checks
  always_ff @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      run_len <= '0;
    end else if (launch) begin
      run_len <= '0;
    end else if (state != ST_IDLE) begin
      run_len <= run_len + 10'h001;
    end
  end

  //********************************************************************
  // alu
  //********************************************************************
  assign alu_operand_a = work_reg; // RULE_06
  assign alu_operand_b = cmd_q.imm;
  assign is_arith = (cmd_q.op == ALU_ADD) || (cmd_q.op == ALU_SUB);

  // bit 4 of the sum is carry out, or borrow on subtract
  always_comb begin
    alu_sum = 5'h00;
    unique case (cmd_q.op)
      ALU_ADD:  alu_sum = {1'b0, alu_operand_a} + {1'b0, alu_operand_b}
                          + {4'h0, flag_reg.c}; // RULE_04 RULE_05
      ALU_SUB:  alu_sum = {1'b0, alu_operand_a} - {1'b0, alu_operand_b}
                          - {4'h0, flag_reg.c}; // RULE_04 RULE_05
      ALU_AND:  alu_sum = {1'b0, alu_operand_a & alu_operand_b};
      ALU_OR:   alu_sum = {1'b0, alu_operand_a | alu_operand_b};
      ALU_XOR:  alu_sum = {1'b0, alu_operand_a ^ alu_operand_b};
      ALU_LOAD: alu_sum = {1'b0, alu_operand_b};
      default:  alu_sum = 5'h00; // codes 6 and 7 are illegal
    endcase
  end

  //********************************************************************
  // working, pointer and flag registers
  //********************************************************************
  // data registers: initialize does not touch them
  always_ff @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      work_reg     <= 4'h0;
      ram_low_ptr  <= 4'h0;
      ram_page_ptr <= '0;
    end else begin
      if (exec_done && cmd_q.flow == FL_ALU) begin
        work_reg <= alu_sum[3:0]; // RULE_06 RULE_25
      end else if (wr_go && hit(aw_q, A_WORK)) begin
        work_reg <= wd_q[3:0];
      end
      if (wr_go && hit(aw_q, A_LOW)) begin
        ram_low_ptr <= wd_q[3:0]; // RULE_14
      end
      if (wr_go && hit(aw_q, A_PAGE)) begin
        ram_page_ptr <= wd_q[PAGE_BITS-1:0]; // RULE_15
      end
    end
  end

  assign ram_addr = {ram_page_ptr, ram_low_ptr}; // RULE_14 RULE_15

  // hardware result wins over a software write in the same cycle
  always_ff @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      flag_reg <= '0;
    end else begin
      if (exec_done && cmd_q.flow == FL_ALU && is_arith) begin
        flag_reg.c <= alu_sum[4]; // RULE_07
      end else if (wr_go && hit(aw_q, A_FLAG)) begin
        flag_reg.c <= wd_q[0];
      end
      if (exec_done && cmd_q.flow == FL_ALU) begin
        flag_reg.f <= is_arith ? alu_sum[4] : (alu_sum[3:0] == 4'h0); // RULE_08
      end else if (wr_go && hit(aw_q, A_FLAG)) begin
        flag_reg.f <= wd_q[1];
      end
      if (init_act) begin
        flag_reg.irq_allow <= 1'b0; // RULE_12
      end else if (irq_take) begin
        flag_reg.irq_allow <= 1'b0; // RULE_11
      end else if (wr_go && hit(aw_q, A_FLAG)) begin
        flag_reg.irq_allow <= wd_q[2]; // RULE_10
      end
      if (wr_go && hit(aw_q, A_FLAG)) begin
        flag_reg.g <= wd_q[3]; // RULE_13
      end
    end
  end

  //********************************************************************
  // program counter and return stack
  //********************************************************************
  // a fifth level overwrites the newest slot (NEST-1), as on the original
  assign push = !init_act && (irq_take || (exec_done && cmd_q.flow == FL_CALL));
  assign push_idx = (depth >= 3'(NEST)) ? 2'(NEST - 1) : depth[1:0];
  assign pop_idx = (depth == 3'h0) ? 2'h0 : 2'(depth - 3'h1);
  assign pc_inc = ext_rom_addr + 11'h001;

  always_ff @(posedge mclk) begin
    if (push) begin
      stack[push_idx] <= irq_take ? ext_rom_addr : pc_inc; // RULE_17
    end
  end

  always_ff @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      ext_rom_addr <= PC_INIT;
      depth        <= 3'h0;
    end else if (init_act) begin
      ext_rom_addr <= PC_INIT; // RULE_23
      depth        <= 3'h0;
    end else if (irq_take) begin
      ext_rom_addr <= IRQ_VEC; // RULE_17
      depth        <= depth + 3'h1;
    end else if (exec_done) begin
      unique case (cmd_q.flow)
        FL_ALU:  ext_rom_addr <= pc_inc; // RULE_22
        FL_CALL: begin
          ext_rom_addr <= cmd_q.target;
          depth <= (depth < 3'(NEST)) ? depth + 3'h1 : depth; // RULE_17
        end
        FL_RET:  begin
          ext_rom_addr <= stack[pop_idx];
          depth <= (depth != 3'h0) ? depth - 3'h1 : depth;
        end
        FL_BRF:  ext_rom_addr <= flag_reg.f ? cmd_q.target : pc_inc; // RULE_09
      endcase
    end
  end

  //********************************************************************
  // axi4-lite slave
  //********************************************************************
  assign wr_go = aw_got && w_got && !bvalid;
  assign wr_ok = hit(aw_q, A_WORK) || hit(aw_q, A_FLAG) || hit(aw_q, A_LOW)
                 || hit(aw_q, A_PAGE) || hit(aw_q, A_CMD) || hit(aw_q, A_STAT)
                 || hit(aw_q, A_PC);

  // address and data latch in either order; one write at a time
  always_ff @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      awready <= 1'b1;
      wready  <= 1'b1;
      aw_got  <= 1'b0;
      w_got   <= 1'b0;
      aw_q    <= 8'h00;
      wd_q    <= 32'h0000_0000;
      bvalid  <= 1'b0;
      bresp   <= RESP_OK;
    end else begin
      if (awvalid && awready) begin
        aw_got  <= 1'b1;
        aw_q    <= awaddr;
        awready <= 1'b0;
      end
      if (wvalid && wready) begin
        w_got  <= 1'b1;
        wd_q   <= wdata & lanes(wstrb);
        wready <= 1'b0;
      end
      if (wr_go) begin
        aw_got <= 1'b0;
        w_got  <= 1'b0;
        bvalid <= 1'b1;
        bresp  <= wr_ok ? RESP_OK : RESP_ERR;
      end
      if (bvalid && bready) begin
        bvalid  <= 1'b0;
        awready <= 1'b1;
        wready  <= 1'b1;
      end
    end
  end

  // read mux, unused bits zero
  always_comb begin
    rd_val = 32'h0000_0000;
    rd_ok  = 1'b1;
    if (hit(araddr, A_WORK)) begin
      rd_val[3:0] = work_reg;
    end else if (hit(araddr, A_FLAG)) begin
      rd_val[3:0] = flag_reg;
    end else if (hit(araddr, A_LOW)) begin
      rd_val[3:0] = ram_low_ptr;
    end else if (hit(araddr, A_PAGE)) begin
      rd_val[PAGE_BITS-1:0] = ram_page_ptr; // RULE_16
    end else if (hit(araddr, A_CMD)) begin
      rd_val = cmd_q;
    end else if (hit(araddr, A_STAT)) begin
      rd_val[S_BUSY] = (state != ST_IDLE);
      rd_val[S_INIT] = init_act;
      rd_val[S_PEND] = irq_pend;
      rd_val[S_DEPTH+2:S_DEPTH] = depth;
      rd_val[S_WORD+7:S_WORD] = ext_rom_word; // RULE_22
    end else if (hit(araddr, A_PC)) begin
      rd_val[10:0] = ext_rom_addr;
    end else begin
      rd_ok = 1'b0;
    end
  end

  always_ff @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      arready <= 1'b1;
      rvalid  <= 1'b0;
      rdata   <= 32'h0000_0000;
      rresp   <= RESP_OK;
    end else if (arvalid && arready) begin
      arready <= 1'b0;
      rvalid  <= 1'b1;
      rdata   <= rd_val;
      rresp   <= rd_ok ? RESP_OK : RESP_ERR;
    end else if (rvalid && rready) begin
      rvalid  <= 1'b0;
      arready <= 1'b1;
    end
  end

  //********************************************************************
  // checks
  //********************************************************************
  chk_init_long: assert property ( // RULE_01
    !init_pin_n[*5] |=> init_act) else $error("init not qualified");
  chk_init_short: assert property ( // RULE_01
    init_pin_n ##1 !init_pin_n[*4] |=> !init_act) else $error("init early");
  chk_irq_long: assert property ( // RULE_02
    (irq_pin_n && !init_act) ##1 (!irq_pin_n && !init_act)[*5]
    |=> ##1 (irq_pend || $past(irq_take) || $past(init_act))) else $error("request lost");
  chk_irq_gate: assert property ( // RULE_10
    irq_take |-> flag_reg.irq_allow && !irq_block_emu && mcyc_cnt == MCYC_LAST)
    else $error("bad interrupt take");
  chk_entry_clear: assert property ( // RULE_11
    irq_take |=> !flag_reg.irq_allow && ext_rom_addr == IRQ_VEC)
    else $error("entry state wrong");
  chk_init_clear: assert property ( // RULE_12
    init_act |=> ext_rom_addr == PC_INIT && !flag_reg.irq_allow && depth == 3'h0)
    else $error("initialize incomplete");
  chk_cycle_len: assert property ( // RULE_19
    exec_done |-> run_len == (cmd_q.two ? 10'(2 * MCYC_CLKS - 1)
                              : 10'(MCYC_CLKS - 1))) else $error("cycle count");
  chk_add_carry: assert property ( // RULE_07
    exec_done && cmd_q.flow == FL_ALU && cmd_q.op == ALU_ADD
    |=> {flag_reg.c, work_reg} == {1'b0, $past(work_reg)}
        + {1'b0, $past(cmd_q.imm)} + {4'h0, $past(flag_reg.c)})
    else $error("add result");
  chk_branch_f: assert property ( // RULE_09
    exec_done && cmd_q.flow == FL_BRF
    |=> ext_rom_addr == ($past(flag_reg.f) ? $past(cmd_q.target)
                         : $past(ext_rom_addr) + 11'h001)) else $error("branch");
  chk_nest_max: assert property ( // RULE_17
    depth <= 3'(NEST)) else $error("nesting overflow");
  chk_page_zero: assert property ( // RULE_16
    arvalid && arready && hit(araddr, A_PAGE) |=> rdata[31:PAGE_BITS] == '0)
    else $error("page upper bits");
endmodule

// >>> fbmcu_core_tb_top.sv
// register level testbench for the controller core datapath
`timescale 1ns/10ps
module fbmcu_core_tb_top import fbmcu_pkg::*;;
  logic        mclk = 1'b0;
  logic        resetn = 1'b0;
  logic [7:0]  awaddr = 8'h00;
  logic [7:0]  araddr = 8'h00;
  logic [31:0] wdata = 32'h0;
  logic        awvalid = 1'b0;
  logic        wvalid = 1'b0;
  logic        bready = 1'b0;
  logic        arvalid = 1'b0;
  logic        rready = 1'b0;
  logic        awready, wready, bvalid, arready, rvalid, clk_out;
  logic [1:0]  bresp, rresp;
  logic [31:0] rdata, v;
  logic        init_n, irq_n;
  logic        irq_blk = 1'b0; // interrupt inhibit, low unless emulating
  logic [10:0] rom_addr;
  logic [6:0]  ram_addr;
  int          error_cnt = 0;
  int          n_compared = 0;
  always #10 mclk = ~mclk;
  fbmcu_src src_u (.mclk(mclk), .init_pin_n(init_n), .irq_pin_n(irq_n));
  fbmcu_core dut_u (.mclk(mclk), .resetn(resetn), .awaddr(awaddr),
    .awvalid(awvalid), .awready(awready), .wdata(wdata), .wstrb(4'hF),
    .wvalid(wvalid), .wready(wready), .bresp(bresp), .bvalid(bvalid),
    .bready(bready), .araddr(araddr), .arvalid(arvalid), .arready(arready),
    .rdata(rdata), .rresp(rresp), .rvalid(rvalid), .rready(rready),
    .init_pin_n(init_n), .irq_pin_n(irq_n), .irq_block_emu(irq_blk),
    .ext_rom_word(8'hA5), .ext_rom_addr(rom_addr), .ram_addr(ram_addr),
    .core_clock_out(clk_out));
  // compare and count
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_compared++;
    if (got !== exp) begin
      error_cnt++;
      $display("[ERR] %0t got %h exp %h", $time, got, exp);
    end
  endtask
  // bus write: each channel held until its ready, bready until bvalid
  task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er);
    @(posedge mclk);
    awaddr  <= a;
    wdata   <= d;
    awvalid <= 1'b1;
    wvalid  <= 1'b1;
    bready  <= 1'b1;
    do begin
      @(posedge mclk);
      if (awready) awvalid <= 1'b0;
      if (wready) wvalid <= 1'b0;
    end while (bvalid !== 1'b1);
    bready <= 1'b0;
    chk(32'(bresp), 32'(er));
  endtask
  // bus read into v
  task automatic rd(input logic [7:0] a);
    @(posedge mclk);
    araddr  <= a;
    arvalid <= 1'b1;
    rready  <= 1'b1;
    do begin
      @(posedge mclk);
      if (arready) arvalid <= 1'b0;
    end while (rvalid !== 1'b1);
    rready <= 1'b0;
    v = rdata;
    chk(32'(rresp), 32'(RESP_OK));
  endtask
  task automatic rc(input logic [7:0] a, input logic [31:0] e);
    rd(a);
    chk(v, e);
  endtask
  // poll until the sequencer drops busy
  task automatic idle();
    do rd(A_STAT); while (v[S_BUSY] !== 1'b0);
  endtask
  task automatic results();
    $display("compared %0d mismatches %0d", n_compared, error_cnt);
    if (error_cnt == 0 && n_compared > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask
  // hang guard, far beyond the few thousand cycles needed
  initial begin
    repeat (20000) @(posedge mclk);
    error_cnt++;
    results();
  end
  initial begin
    repeat (8) @(posedge mclk);
    resetn <= 1'b1;
    wr(A_PAGE, 32'hF, RESP_OK);
    rc(A_PAGE, 32'h7);
    wr(A_LOW, 32'h5, RESP_OK);
    chk(32'(ram_addr), 32'h75);
    wr(8'h40, 32'h1, RESP_ERR);
    rc(A_STAT, 32'hA500);
    wr(A_FLAG, 32'h8, RESP_OK);
    rc(A_FLAG, 32'h8);
    $display("end registers");
    wr(A_FLAG, 32'h9, RESP_OK);
    wr(A_WORK, 32'h9, RESP_OK);
    wr(A_CMD, 32'h08, RESP_OK);
    idle();
    rc(A_WORK, 32'h2);
    rc(A_FLAG, 32'hB);
    wr(A_CMD, 32'hAF, RESP_OK);
    repeat (300) @(posedge mclk);
    rc(A_STAT, 32'hA501);
    repeat (110) @(posedge mclk);
    rc(A_STAT, 32'hA500);
    rc(A_FLAG, 32'h9);
    wr(A_CMD, 32'h01000300, RESP_OK);
    idle();
    rc(A_PC, 32'h3);
    $display("end alu");
    wr(A_FLAG, 32'h4, RESP_OK);
    src_u.pulse(1'b1, 4);
    begin : clk_win
      int hi;
      hi = 0;
      repeat (MCYC_CLKS) begin
        @(posedge mclk);
        hi += int'(clk_out);
      end
      chk(32'(hi), 32'(MCYC_CLKS / 2));
    end
    repeat (50) @(posedge mclk);
    rc(A_STAT, 32'hA500);
    irq_blk <= 1'b1;
    src_u.pulse(1'b1, 6);
    repeat (250) @(posedge mclk);
    rc(A_STAT, 32'hA504);
    irq_blk <= 1'b0;
    repeat (250) @(posedge mclk);
    rc(A_PC, 32'h1);
    rc(A_FLAG, 32'h0);
    rc(A_STAT, 32'hA510);
    $display("end interrupt");
    wr(A_FLAG, 32'h4, RESP_OK);
    src_u.pulse(1'b0, 6);
    rc(A_PC, 32'h0);
    rc(A_FLAG, 32'h0);
    rc(A_WORK, 32'h2);
    $display("end initialize");
    wr(A_CMD, 32'h13, RESP_OK);
    idle();
    rc(A_WORK, 32'hF);
    rc(A_FLAG, 32'h3);
    wr(A_CMD, 32'h01000300, RESP_OK);
    idle();
    rc(A_PC, 32'h100);
    wr(A_CMD, 32'h00200100, RESP_OK);
    idle();
    rc(A_PC, 32'h20);
    rc(A_STAT, 32'hA510);
    wr(A_CMD, 32'h00000200, RESP_OK);
    idle();
    rc(A_PC, 32'h101);
    chk(32'(rom_addr), 32'h101);
    $display("end flow");
    results();
  end
endmodule

// >>> fbmcu_pkg.sv
// shared constants and types for the 4-bit controller core datapath
//**********************************************************************
// Notes on behaviour
// RULE_01: initialize runs after init pin low over four
// RULE_02: interrupt taken only after pin low over four
// RULE_03: source holds interrupt pin high two cycles between
// RULE_04: alu adds two nibbles plus previous carry
// RULE_05: alu yields one nibble and one carry
// RULE_06: working register feeds and receives alu data
// RULE_07: flag bit 0 keeps carry or borrow
// RULE_08: flag bit 1 follows latest alu outcome
// RULE_09: conditional branch tests flag bit 1
// RULE_10: flag bit 2 enables interrupts, program writable
// RULE_11: interrupt entry clears the enable flag
// RULE_12: initialize clears the interrupt enable flag
// RULE_13: flag bit 3 is plain software storage
// RULE_14: low pointer gives low four ram address bits
// RULE_15: page pointer gives two or three upper bits
// RULE_16: unused page pointer bits read zero
// RULE_17: four return levels, interrupt entry included
// RULE_18: one interrupt input, one level, no priority
// RULE_19: instructions last one or two machine cycles
// RULE_20: emulator inhibit pin held low when unused
// RULE_21: test pin held high outside factory test
// RULE_22: program address out, program word in
// RULE_23: initialize clears the program counter
// RULE_24: requests align to the machine cycle timer
// RULE_25: initialize leaves data registers untouched
//**********************************************************************
package fbmcu_pkg;
  localparam int         CLK_MHZ   = 50;     // mclk rate
  localparam int         MCYC_NS   = 4000;   // one machine cycle
  localparam int         MCYC_CLKS = MCYC_NS * CLK_MHZ / 1000;
  localparam int         MCYC_W    = $clog2(MCYC_CLKS);
  localparam logic [MCYC_W-1:0] MCYC_LAST = MCYC_W'(MCYC_CLKS - 1);
  localparam logic [MCYC_W-1:0] MCYC_HALF = MCYC_W'(MCYC_CLKS / 2);
  localparam logic [2:0] FILT_CNT  = 3'h4;   // lows that must be exceeded
  localparam logic [10:0] PC_INIT  = 11'h000;
  // register byte offsets
  localparam logic [7:0] A_WORK = 8'h00;
  localparam logic [7:0] A_FLAG = 8'h04;
  localparam logic [7:0] A_LOW  = 8'h08;
  localparam logic [7:0] A_PAGE = 8'h0C;
  localparam logic [7:0] A_CMD  = 8'h10;
  localparam logic [7:0] A_STAT = 8'h14;
  localparam logic [7:0] A_PC   = 8'h18;
  // status field positions
  localparam int S_BUSY  = 0;
  localparam int S_INIT  = 1;
  localparam int S_PEND  = 2;
  localparam int S_DEPTH = 4;
  localparam int S_WORD  = 8;
  localparam logic [1:0] RESP_OK  = 2'h0;
  localparam logic [1:0] RESP_ERR = 2'h2;
  typedef enum logic [2:0] {
    ALU_ADD = 3'h0, ALU_SUB = 3'h1, ALU_AND = 3'h2,
    ALU_OR = 3'h3, ALU_XOR = 3'h4, ALU_LOAD = 3'h5
  } fbmcu_op_t;
  typedef enum logic [1:0] {
    FL_ALU = 2'h0, FL_CALL = 2'h1, FL_RET = 2'h2, FL_BRF = 2'h3
  } fbmcu_flow_t;
  typedef enum logic [1:0] {
    ST_IDLE = 2'h0, ST_RUN1 = 2'h1, ST_RUN2 = 2'h3
  } fbmcu_state_t;
  typedef struct packed {
    logic [4:0]  rsv_hi;
    logic [10:0] target;
    logic [5:0]  rsv;
    fbmcu_flow_t flow;
    logic        two;
    fbmcu_op_t   op;
    logic [3:0]  imm;
  } fbmcu_cmd_t;
  typedef struct packed {
    logic g;
    logic irq_allow;
    logic f;
    logic c;
  } fbmcu_flag_t;
endpackage

// >>> fbmcu_src.sv
// model of the external initialize and interrupt sources
`timescale 1ns/10ps
module fbmcu_src (
  input  wire logic mclk,
  output logic      init_pin_n,
  output logic      irq_pin_n
);
  // the core has no factory test line: it counts as high all run
  // both request lines idle high
  initial begin
    init_pin_n = 1'b1;
    irq_pin_n  = 1'b1;
  end
  // low for n cycles, then high two before any new request
  task automatic pulse(input bit irq, input int n);
    repeat (n) begin
      @(posedge mclk);
      if (irq) irq_pin_n <= 1'b0;
      else init_pin_n <= 1'b0;
    end
    @(posedge mclk);
    irq_pin_n  <= 1'b1;
    init_pin_n <= 1'b1;
    repeat (2) @(posedge mclk);
  endtask
endmodule
